//--- hw/flush_fmt_pkg.sv
// Purpose: shared constants and types for the flush / track format command block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   task-file style registers sit at chosen word offsets

package flush_fmt_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] off_command   = 8'h00;
	localparam logic [7:0] off_sector    = 8'h04;
	localparam logic [7:0] off_cyl_low   = 8'h08;
	localparam logic [7:0] off_cyl_high  = 8'h0c;
	localparam logic [7:0] off_dev_head  = 8'h10;
	localparam logic [7:0] off_error     = 8'h14;
	localparam logic [7:0] off_status    = 8'h18;
	localparam logic [7:0] off_irq_stat  = 8'h1c;
	localparam logic [7:0] off_irq_en    = 8'h20;
	localparam logic [7:0] off_irq_clr   = 8'h24;
	localparam logic [7:0] off_geometry  = 8'h28;
	localparam logic [7:0] off_cache_cnt = 8'h2c;
	localparam logic [7:0] off_fmt_data  = 8'h30;

	// ----------------------------------------------------------------
	// opcodes and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] op_flush      = 8'he7;
	localparam logic [7:0] op_flush_ext  = 8'hea;
	localparam logic [7:0] op_fmt_track  = 8'h50;
	localparam int         dh_lba_bit    = 6;
	localparam int         err_abort_bit = 2;
	localparam int         err_idnf_bit  = 4;
	localparam int         st_busy_bit   = 7;
	localparam int         st_ready_bit  = 6;
	localparam int         st_seek_bit   = 4;
	localparam int         st_err_bit    = 0;

	// ----------------------------------------------------------------
	// reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  rst_status      = 8'h50;
	localparam logic [7:0]  rst_sec_per_trk = 8'h3f;
	localparam logic [3:0]  rst_heads       = 4'hf;
	localparam logic [27:0] rst_max_lba     = 28'h0ffffff;
	localparam int          media_write_ns  = 40;
	localparam int          clk_period_ns   = 10;
	localparam logic [3:0]  media_write_cyc =
		4'((media_write_ns + clk_period_ns - 1) / clk_period_ns);
	localparam int          fmt_table_words = 128;

	typedef enum logic [2:0] {
		st_idle   = 3'b000,
		st_flush  = 3'b001,
		st_table  = 3'b010,
		st_format = 3'b011,
		st_done   = 3'b100
	} cmd_state_t;

	typedef struct packed {
		logic [7:0] sector;
		logic [7:0] cyl_low;
		logic [7:0] cyl_high;
		logic [7:0] dev_head;
	} task_file_t;

	typedef struct packed {
		logic        awt;
		logic        wt;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  bresp;
	} axil_state_t;

endpackage : flush_fmt_pkg

//--- hw/flush_fmt_cmd.sv
// Purpose: executes cache flush (normal, ext) and single track format commands
// Assumes: media write engine takes zero-fill sector requests, one per strobe
// Notes:   registers over AXI4-Lite; events raise a level interrupt
//
// Summary of operation
// - flush opcode drains every pending cache entry before good status.
// - extended flush opcode behaves exactly like the plain flush.
// - format opcode formats exactly one logical track from task-file address.
// - format writes zero to each good sector, no read-back verify.
// - host format table sector is accepted but its contents ignored.
// - track laid out 1:1 interleave regardless of requested numbering.
// - after LBA format, current block address returned in same registers.
// - out-of-range block address ends format with abort flag set.
// - LBA mode formats the whole track holding the given block.

`timescale 1ns/100ps

module flush_fmt_cmd
	import flush_fmt_pkg::*;
(
	input  wire logic        sys_clk,        // 100 MHz clock
	input  wire logic        rst_n,          // sync reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // write strobes
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	input  wire logic        cache_dirty,    // write cache holds pending entries
	output logic             cache_drain,    // request to write one cache entry
	input  wire logic        cache_done,     // one cache entry reached media
	output logic             media_zero_wr,  // write zero to one sector
	output logic [27:0]      media_lba,      // sector address for zero write
	input  wire logic        media_done,     // sector write finished
	input  wire logic        media_bad,      // sector is a known defect
	output logic             irq             // level interrupt
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		axil_state_t bus;
		cmd_state_t  state;
		task_file_t  tf;
		logic [7:0]  command;
		logic [7:0]  error_flags;
		logic [7:0]  device_status;
		logic [7:0]  sec_per_trk;
		logic [3:0]  heads;
		logic [27:0] max_lba;
		logic [27:0] trk_base;
		logic [7:0]  sec_idx;
		logic [7:0]  tbl_cnt;
		logic [15:0] drained;
		logic        req_out;
		logic        lba_mode;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_en;
	} regs_t;

	regs_t r;
	regs_t next_r;

	logic        wr_go;
	logic        rd_go;
	logic [27:0] lba_in;
	logic [27:0] chs_lba;
	logic [27:0] trk_lba;
	logic [2:0]  events;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        wr_hit;

	// ----------------------------------------------------------------
	// address decode helpers
	// ----------------------------------------------------------------
	// assemble the target address from the task file
	assign lba_in  = {r.tf.dev_head[3:0], r.tf.cyl_high, r.tf.cyl_low, r.tf.sector};
	assign chs_lba = 28'(({r.tf.cyl_high, r.tf.cyl_low} * (r.heads + 5'd1)
		+ r.tf.dev_head[3:0]) * r.sec_per_trk);
	// track start that contains the block
	assign trk_lba = 28'((lba_in / r.sec_per_trk) * r.sec_per_trk);

	assign wr_go = r.bus.awt && r.bus.wt && !r.bus.bvalid;
	assign rd_go = s_axi_arvalid && !r.bus.rvalid;

	// register read mux
	always_comb begin
		rd_word = 32'h0;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			off_command:   rd_word = {24'h0, r.command};
			off_sector:    rd_word = {24'h0, r.tf.sector};
			off_cyl_low:   rd_word = {24'h0, r.tf.cyl_low};
			off_cyl_high:  rd_word = {24'h0, r.tf.cyl_high};
			off_dev_head:  rd_word = {24'h0, r.tf.dev_head};
			off_error:     rd_word = {24'h0, r.error_flags};
			off_status:    rd_word = {24'h0, r.device_status};
			off_irq_stat:  rd_word = {29'h0, r.irq_stat};
			off_irq_en:    rd_word = {29'h0, r.irq_en};
			off_irq_clr:   rd_word = 32'h0;
			off_geometry:  rd_word = {20'h0, r.heads, r.sec_per_trk};
			off_cache_cnt: rd_word = {16'h0, r.drained};
			off_fmt_data:  rd_word = 32'h0;
			default:       rd_hit  = 1'b0;
		endcase
	end

	always_comb begin
		case (r.bus.awaddr)
			off_command, off_sector, off_cyl_low, off_cyl_high, off_dev_head,
			off_irq_en, off_irq_clr, off_geometry, off_fmt_data,
			off_error, off_status, off_irq_stat, off_cache_cnt: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		events = 3'b000;

		// axi write channel capture
		if (s_axi_awvalid && !r.bus.awt) begin
			next_r.bus.awt    = 1'b1;
			next_r.bus.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r.bus.wt) begin
			next_r.bus.wt    = 1'b1;
			next_r.bus.wdata = s_axi_wdata;
		end
		if (r.bus.bvalid && s_axi_bready) begin
			next_r.bus.bvalid = 1'b0;
		end
		if (r.bus.rvalid && s_axi_rready) begin
			next_r.bus.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_r.bus.rvalid = 1'b1;
			next_r.bus.rdata  = rd_word;
			next_r.bus.rresp  = rd_hit ? 2'b00 : 2'b10;
		end

		// engine
		next_r.req_out = 1'b0;
		case (r.state)
			st_idle: begin
			end
			st_flush: begin
				if (cache_done) begin
					next_r.drained = r.drained + 16'd1;
				end
				// only report good status once nothing is left
				if (!cache_dirty && !r.req_out) begin
					next_r.state = st_done;
				end else if (cache_dirty && !r.req_out && !cache_done) begin
					next_r.req_out = 1'b1;
				end else begin
					next_r.req_out = r.req_out && !cache_done;
				end
			end
			st_table: begin
				// table sector words counted and dropped
				if (r.tbl_cnt == 8'(fmt_table_words)) begin
					next_r.state = st_format;
				end
			end
			st_format: begin
				// sectors written in order, 1:1 interleave
				if (r.sec_idx == r.sec_per_trk) begin
					next_r.state = st_done;
				end else if (!r.req_out || media_done) begin
					if (media_done || media_bad) begin
						next_r.sec_idx = r.sec_idx + 8'd1;
					end
					next_r.req_out = !media_bad && !media_done;
					if (media_done) begin
						next_r.req_out = 1'b0;
					end
				end else begin
					next_r.req_out = 1'b1;
				end
			end
			st_done: begin
				// results written on the same edge that busy drops
				next_r.device_status[st_busy_bit] = 1'b0;
				next_r.device_status[st_err_bit]  = |r.error_flags;
				next_r.state = st_idle;
				events[0] = (r.command == op_flush) || (r.command == op_flush_ext);
				events[1] = (r.command == op_fmt_track);
				events[2] = |r.error_flags;
				if (r.lba_mode && r.command == op_fmt_track
					&& !r.error_flags[err_abort_bit]) begin
					// return current block address
					{next_r.tf.dev_head[3:0], next_r.tf.cyl_high,
						next_r.tf.cyl_low, next_r.tf.sector} =
						28'(r.trk_base + r.sec_idx - 28'd1);
				end
			end
			default: next_r.state = st_idle;
		endcase

		// register writes
		if (wr_go) begin
			next_r.bus.awt    = 1'b0;
			next_r.bus.wt     = 1'b0;
			next_r.bus.bvalid = 1'b1;
			next_r.bus.bresp  = wr_hit ? 2'b00 : 2'b10;
			case (r.bus.awaddr)
				off_sector:   if (r.state == st_idle) next_r.tf.sector   = r.bus.wdata[7:0];
				off_cyl_low:  if (r.state == st_idle) next_r.tf.cyl_low  = r.bus.wdata[7:0];
				off_cyl_high: if (r.state == st_idle) next_r.tf.cyl_high = r.bus.wdata[7:0];
				off_dev_head: if (r.state == st_idle) next_r.tf.dev_head = r.bus.wdata[7:0];
				off_irq_en:   next_r.irq_en = r.bus.wdata[2:0];
				off_irq_clr:  next_r.irq_stat = r.irq_stat & ~r.bus.wdata[2:0];
				off_geometry: if (r.state == st_idle) begin
					next_r.sec_per_trk = r.bus.wdata[7:0];
					next_r.heads       = r.bus.wdata[11:8];
				end
				off_fmt_data: if (r.state == st_table) next_r.tbl_cnt = r.tbl_cnt + 8'd1;
				off_command: if (r.state == st_idle) begin
					next_r.command     = r.bus.wdata[7:0];
					next_r.error_flags = 8'h00;
					next_r.drained     = 16'h0;
					next_r.sec_idx     = 8'h00;
					next_r.tbl_cnt     = 8'h00;
					next_r.lba_mode    = r.tf.dev_head[dh_lba_bit];
					next_r.device_status[st_busy_bit] = 1'b1;
					next_r.device_status[st_err_bit]  = 1'b0;
					case (r.bus.wdata[7:0])
						op_flush, op_flush_ext: next_r.state = st_flush;
						op_fmt_track: begin
							next_r.trk_base = r.tf.dev_head[dh_lba_bit] ? trk_lba : chs_lba;
							if (r.tf.dev_head[dh_lba_bit] && lba_in > r.max_lba) begin
								next_r.error_flags[err_abort_bit] = 1'b1;
								next_r.state = st_done;
							end else begin
								next_r.state = r.bus.wdata[8] ? st_table : st_format;
							end
						end
						default: begin
							next_r.error_flags[err_abort_bit] = 1'b1;
							next_r.state = st_done;
						end
					endcase
				end
				default: begin
				end
			endcase
		end

		// events win over a simultaneous clear
		next_r.irq_stat = next_r.irq_stat | events;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r               <= '0;
			r.state         <= st_idle;
			r.device_status <= rst_status;
			r.sec_per_trk   <= rst_sec_per_trk;
			r.heads         <= rst_heads;
			r.max_lba       <= rst_max_lba;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !r.bus.awt;
	assign s_axi_wready  = !r.bus.wt;
	assign s_axi_bvalid  = r.bus.bvalid;
	assign s_axi_bresp   = r.bus.bresp;
	assign s_axi_arready = !r.bus.rvalid;
	assign s_axi_rvalid  = r.bus.rvalid;
	assign s_axi_rdata   = r.bus.rdata;
	assign s_axi_rresp   = r.bus.rresp;
	assign cache_drain   = (r.state == st_flush) && r.req_out;
	assign media_zero_wr = (r.state == st_format) && r.req_out;
	assign media_lba     = 28'(r.trk_base + r.sec_idx);
	assign irq           = |(r.irq_stat & r.irq_en);

endmodule : flush_fmt_cmd

//--- dv/flush_fmt_cmd_asserts.sv
// Purpose: port-level checks for the flush and track format block
// Assumes: bound to every flush_fmt_cmd instance
// Notes:   one clock domain, reset disables all checks
`timescale 1ns/100ps
module flush_fmt_cmd_asserts (
	input wire logic        sys_clk,       // clock
	input wire logic        rst_n,         // sync reset
	input wire logic        s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata,   // read data
	input wire logic [1:0]  s_axi_rresp,   // read response
	input wire logic        s_axi_rvalid,  // read data valid
	input wire logic        s_axi_rready,  // read data ready
	input wire logic [1:0]  s_axi_bresp,   // write response
	input wire logic        s_axi_bvalid,  // write response valid
	input wire logic        s_axi_bready,  // write response ready
	input wire logic        cache_dirty,   // cache entries pending
	input wire logic        cache_drain,   // drain request
	input wire logic        cache_done,    // entry written
	input wire logic        media_zero_wr, // zero write request
	input wire logic [27:0] media_lba,     // sector address
	input wire logic        media_done,    // sector written
	input wire logic        irq            // interrupt
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready not tied to idle read");
	AST_RESET_IDLE: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("outputs not idle after reset");
	AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
		else $error("slave error read carries data");
	AST_DRAIN_HOLD: assert property (cache_drain && !cache_done |=> cache_drain)
		else $error("drain request dropped before done");
	AST_DRAIN_CAUSE: assert property ($rose(cache_drain) |-> $past(cache_dirty))
		else $error("drain requested with clean cache");
	AST_ZERO_HOLD: assert property (media_zero_wr && !media_done |=>
		media_zero_wr && $stable(media_lba)) else $error("zero write changed before done");
	AST_ONE_JOB: assert property (!(media_zero_wr && cache_drain))
		else $error("flush and format active together");
endmodule : flush_fmt_cmd_asserts

bind flush_fmt_cmd flush_fmt_cmd_asserts asserts_u (.sys_clk(sys_clk), .rst_n(rst_n),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .cache_dirty(cache_dirty),
	.cache_drain(cache_drain), .cache_done(cache_done), .media_zero_wr(media_zero_wr),
	.media_lba(media_lba), .media_done(media_done), .irq(irq));

//--- dv/media_model.sv
// Purpose: behavioural write cache and media behind the command block
// Assumes: one request outstanding at a time
// Notes:   sector answers alternate prompt and slow
`timescale 1ns/100ps
module media_model (
	input  wire logic        sys_clk,       // clock
	input  wire logic        cache_drain,   // drain request
	output logic             cache_dirty,   // entries pending
	output logic             cache_done,    // one entry written
	input  wire logic        media_zero_wr, // zero write request
	input  wire logic [27:0] media_lba,     // sector address
	output logic             media_done,    // sector written
	output logic             media_bad      // defect sector
);
	int          pending = 0;      // entries left in cache
	int          lag = 0;          // cycles waited on a sector
	logic        slow = 1'b0;      // next answer is slow
	logic [27:0] bad_lba = 28'h22; // one defect sector
	logic [27:0] wr_q[$];          // sectors zeroed
	initial cache_done = 1'b0;
	initial media_done = 1'b0;
	// answer drain and zero-write requests with one-cycle pulses
	always @(posedge sys_clk) begin
		cache_done <= 1'b0;
		media_done <= 1'b0;
		if (cache_drain && !cache_done && pending > 0) begin
			cache_done <= 1'b1;
			pending <= pending - 1;
		end
		if (media_zero_wr && !media_done) begin
			if (lag >= (slow ? 3 : 0)) begin
				media_done <= 1'b1;
				wr_q.push_back(media_lba);
				lag = 0;
				slow = !slow;
			end else begin
				lag = lag + 1;
			end
		end
	end
	assign cache_dirty = (pending != 0);
	assign media_bad = (media_lba == bad_lba);
endmodule : media_model

//--- dv/cache_flush_track_format_cmds_tb.sv
// Purpose: self-checking bench for the flush and track format block
// Assumes: media_model answers cache and sector requests
// Notes:   table rows first, then mask, unmapped and reset cases
`timescale 1ns/100ps
module cache_flush_track_format_cmds_tb;
	import flush_fmt_pkg::*;
	typedef struct packed {
		logic [8:0]  cmd;   // command word, bit8 sends a table
		logic        lba;   // logical addressing
		logic [27:0] addr;  // {head, cyl, sector} or block
		logic [7:0]  n;     // cache entries
		logic [27:0] first; // first sector of track
		logic [2:0]  ev;    // expected events
	} row_t;
	row_t rows[8] = '{'{9'h0e7, 1'b0, 28'h0, 8'd3, 28'h0, 3'b001},
		'{9'h0ea, 1'b0, 28'h0, 8'd5, 28'h0, 3'b001},
		'{9'h050, 1'b0, 28'h3000200, 8'd0, 28'h118, 3'b010},
		'{9'h050, 1'b1, 28'h0234567, 8'd0, 28'h0234560, 3'b010},
		'{9'h150, 1'b1, 28'h9, 8'd0, 28'h8, 3'b010},
		'{9'h050, 1'b1, 28'h21, 8'd0, 28'h20, 3'b010},
		'{9'h05a, 1'b0, 28'h0, 8'd0, 28'h0, 3'b100},
		'{9'h050, 1'b1, 28'h1234567, 8'd0, 28'h0, 3'b110}};
	logic        sys_clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
	logic        arv = 1'b0, rre = 1'b0, awr, wr, bv, arr, rv, irq;
	logic        c_dirty, c_drain, c_done, m_wr, m_done, m_bad;
	logic [7:0]  awa = 8'h0, ara = 8'h0;
	logic [31:0] wdat = 32'h0, rd, rdv, got;
	logic [1:0]  br, rr, resp;
	logic [27:0] m_lba;
	row_t        r;
	int          errors = 0, check_count = 0, k;

	flush_fmt_cmd dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdat), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.cache_dirty(c_dirty), .cache_drain(c_drain), .cache_done(c_done),
		.media_zero_wr(m_wr), .media_lba(m_lba), .media_done(m_done),
		.media_bad(m_bad), .irq(irq));
	media_model media_u (.sys_clk(sys_clk), .cache_drain(c_drain), .cache_dirty(c_dirty),
		.cache_done(c_done), .media_zero_wr(m_wr), .media_lba(m_lba),
		.media_done(m_done), .media_bad(m_bad));

	always #5 sys_clk = ~sys_clk;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// one write, each channel released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		awa <= a;
		wdat <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
		end while (!(bre && bv));
		resp = br;
		bre <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge sys_clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arv && arr) arv <= 1'b0;
		end while (!(rre && rv));
		rdv = rd;
		resp = rr;
		rre <= 1'b0;
	endtask : axr

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			axr(off_status);
			n++;
		end while (rdv[st_busy_bit] !== 1'b0 && n < 400);
		check("idle reached", rdv[st_busy_bit], 1'b0);
	endtask : wait_idle

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		axr(off_status);
		check("reset status", rdv, 32'h50);
		axr(off_error);
		check("reset error", rdv, 32'h0);
	endtask : do_reset

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial begin
		repeat (50000) @(posedge sys_clk);
		errors++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		axw(off_geometry, 32'h0f08);
		axw(off_irq_en, 32'h7);
		foreach (rows[i]) begin
			r = rows[i];
			media_u.pending = r.ev[0] ? int'(r.n) : 0;
			media_u.wr_q.delete();
			axw(off_sector, {24'h0, r.addr[7:0]});
			axw(off_cyl_low, {24'h0, r.addr[15:8]});
			axw(off_cyl_high, {24'h0, r.addr[23:16]});
			axw(off_dev_head, {24'h0, 1'b1, r.lba, 2'b10, r.addr[27:24]});
			axw(off_command, {23'h0, r.cmd});
			axr(off_status);
			if (!r.ev[2]) check("busy", rdv[st_busy_bit], 1'b1);
			if (r.cmd[8]) for (k = 0; k < fmt_table_words; k++) axw(off_fmt_data, 32'hffffffff);
			wait_idle();
			axr(off_error);
			check("error", rdv, r.ev[2] ? 32'h4 : 32'h0);
			axr(off_status);
			check("status", rdv, r.ev[2] ? 32'h51 : 32'h50);
			check("pending", media_u.pending, 0);
			axr(off_cache_cnt);
			check("drained", rdv, r.ev[0] ? {24'h0, r.n} : 32'h0);
			k = 0;
			for (int s = 0; s < 8; s++)
				if (r.ev[1] && !r.ev[2] && r.first + s != media_u.bad_lba) begin
					check("zeroed sector", media_u.wr_q[k], r.first + s);
					k++;
				end
			check("sector count", media_u.wr_q.size(), k);
			if (r.lba && r.ev[1] && !r.ev[2]) begin
				axr(off_sector);
				got[7:0] = rdv[7:0];
				axr(off_cyl_low);
				got[15:8] = rdv[7:0];
				axr(off_cyl_high);
				got[23:16] = rdv[7:0];
				axr(off_dev_head);
				check("returned block", {4'h0, rdv[3:0], got[23:0]}, r.first + 28'd7);
			end
			axr(off_irq_stat);
			check("events", rdv, {29'h0, r.ev});
			check("irq set", irq, 1'b1);
			axw(off_irq_clr, 32'h7);
			@(posedge sys_clk);
			check("irq cleared", irq, 1'b0);
		end
		// masked event keeps the line low
		axw(off_irq_en, 32'h0);
		axw(off_command, {24'h0, op_flush});
		wait_idle();
		axr(off_irq_stat);
		check("masked event", rdv, 32'h1);
		check("masked irq", irq, 1'b0);
		// unmapped place answers with slave error
		axr(8'h3c);
		check("unmapped rresp", resp, 2'b10);
		check("unmapped rdata", rdv, 32'h0);
		axw(8'h3c, 32'h1);
		check("unmapped bresp", resp, 2'b10);
		do_reset();
		finish_test();
	end
endmodule : cache_flush_track_format_cmds_tb
